//--- hw/mies_params.svh
`ifndef MIES_PARAMS_SVH
`define MIES_PARAMS_SVH
`define MIES_TRAP_VECTOR   11'h001
`define MIES_TRAP_CYCLES   2'h3
`define MIES_BRANCH_CYCLES 2'h2
`define MIES_SEC_MIN       4'h5
`define MIES_SEC_MAX       4'hf
`define MIES_STACK_DEPTH   8
`define MIES_STACK_PTR_W   3
`define MIES_STACK_PTR_RST 3'h1
`define MIES_PC_RST        11'h000
`define MIES_ACC_RST       8'h00
`define MIES_ZERO_BYTE     8'h00
`endif

//--- hw/mies_pkg.sv
`include "mies_params.svh"
package mies_pkg;
  typedef enum logic [2:0] {
    MIES_OP_NONE,
    MIES_OP_TRAP,
    MIES_OP_OR_IMM,
    MIES_OP_OR_REG,
    MIES_OP_ST_SEC,
    MIES_OP_LD_SEC,
    MIES_OP_LJUMP,
    MIES_OP_LONG_CALL_OP
  } mies_op_e;

  typedef struct packed {
    mies_op_e    op;
    logic [10:0] pc;
    logic [10:0] target;
    logic [7:0]  imm;
    logic [6:0]  reg_addr;
    logic        dest_reg;
    logic [3:0]  sec_sel;
  } mies_instr_s;

  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [7:0]  data;
  } mies_regwr_s;
endpackage : mies_pkg

//--- hw/mies_stack.sv
`timescale 1ns/1ps
`include "mies_params.svh"
module mies_stack (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_push,
  input  wire logic [10:0] i_push_addr,
  output logic [2:0]       o_ptr,
  output logic [10:0]      o_top
);
  import mies_pkg::*;
  logic [10:0] mem_r [`MIES_STACK_DEPTH];
  logic [2:0]  ptr_r;
  logic [2:0]  ptr_nxt;

  always_comb begin
    ptr_nxt = ptr_r;
    if (i_push) begin
      ptr_nxt = ptr_r + 3'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_r <= `MIES_STACK_PTR_RST;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // Entries hold no reset; only the pointer marks validity
  always_ff @(posedge i_mclk) begin
    if (i_push) begin
      mem_r[ptr_r] <= i_push_addr;
    end
  end

  assign o_ptr = ptr_r;
  assign o_top = mem_r[ptr_r - 3'h1];
endmodule : mies_stack

//--- hw/mies_core.sv
`timescale 1ns/1ps
`include "mies_params.svh"
module mies_core (
  input  wire logic                 i_mclk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_instr_valid,
  input  wire mies_pkg::mies_instr_s i_instr,
  input  wire logic [7:0]           i_reg_rdata,
  input  wire logic [7:0]           i_sec_rdata,
  output logic                      o_busy,
  output logic                      o_flush,
  output logic                      o_pc_load,
  output logic [10:0]               o_pc,
  output logic [7:0]                o_acc,
  output logic                      o_zero,
  output mies_pkg::mies_regwr_s     o_reg_wr,
  output logic                      o_sec_wr,
  output logic                      o_sec_rd,
  output logic [3:0]                o_sec_sel,
  output logic [7:0]                o_sec_wdata,
  output logic [2:0]                o_stack_ptr,
  output logic                      o_stack_push
);
  import mies_pkg::*;

  typedef enum logic [1:0] {MIES_IDLE, MIES_WAIT} mies_state_e;

  mies_state_e  state_r, state_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic [10:0]  pc_r, pc_nxt;
  logic [10:0]  tgt_r, tgt_nxt;
  logic         pcld_r, pcld_nxt;
  logic         flush_r, flush_nxt;
  logic         busy_r, busy_nxt;
  logic [7:0]   acc_r, acc_nxt;
  logic         zero_r, zero_nxt;
  mies_regwr_s  rw_r, rw_nxt;
  logic         sw_r, sw_nxt;
  logic         sr_r, sr_nxt;
  logic [3:0]   ssel_r, ssel_nxt;
  logic [7:0]   swd_r, swd_nxt;
  logic         push;
  logic         push_r;
  logic [10:0]  push_addr;
  logic [2:0]   sptr;
  logic [7:0]   or_res;
  logic         sec_ok;

  mies_stack u_stack (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_push      (push),
    .i_push_addr (push_addr),
    .o_ptr       (sptr),
    .o_top       ()
  );

  assign sec_ok = (i_instr.sec_sel >= `MIES_SEC_MIN) && (i_instr.sec_sel <= `MIES_SEC_MAX);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    pc_nxt    = pc_r;
    tgt_nxt   = tgt_r;
    pcld_nxt  = 1'b0;
    flush_nxt = 1'b0;
    acc_nxt   = acc_r;
    zero_nxt  = zero_r;
    rw_nxt    = '0;
    sw_nxt    = 1'b0;
    sr_nxt    = 1'b0;
    ssel_nxt  = ssel_r;
    swd_nxt   = swd_r;
    push      = 1'b0;
    push_addr = i_instr.pc + 11'h001;
    or_res    = acc_r | i_instr.imm;
    case (state_r)
      MIES_IDLE: begin
        if (i_instr_valid) begin
          case (i_instr.op)
            MIES_OP_TRAP: begin
              push      = 1'b1;
              flush_nxt = 1'b1;
              tgt_nxt   = `MIES_TRAP_VECTOR;
              cnt_nxt   = `MIES_TRAP_CYCLES - 2'h1;
              state_nxt = MIES_WAIT;
            end
            MIES_OP_OR_IMM: begin
              or_res   = acc_r | i_instr.imm;
              acc_nxt  = or_res;
              zero_nxt = (or_res == `MIES_ZERO_BYTE);
            end
            MIES_OP_OR_REG: begin
              or_res   = acc_r | i_reg_rdata;
              zero_nxt = (or_res == `MIES_ZERO_BYTE);
              if (i_instr.dest_reg) begin
                rw_nxt.wr   = 1'b1;
                rw_nxt.addr = i_instr.reg_addr;
                rw_nxt.data = or_res;
              end else begin
                acc_nxt = or_res;
              end
            end
            MIES_OP_ST_SEC: begin
              if (sec_ok) begin
                sw_nxt   = 1'b1;
                ssel_nxt = i_instr.sec_sel;
                swd_nxt  = acc_r;
              end
            end
            MIES_OP_LD_SEC: begin
              // Read data is combinational from the page, sampled same cycle
              if (sec_ok) begin
                sr_nxt   = 1'b1;
                ssel_nxt = i_instr.sec_sel;
                acc_nxt  = i_sec_rdata;
              end
            end
            MIES_OP_LJUMP: begin
              flush_nxt = 1'b1;
              tgt_nxt   = i_instr.target;
              cnt_nxt   = `MIES_BRANCH_CYCLES - 2'h1;
              state_nxt = MIES_WAIT;
            end
            MIES_OP_LONG_CALL_OP: begin
              push      = 1'b1;
              flush_nxt = 1'b1;
              tgt_nxt   = i_instr.target;
              cnt_nxt   = `MIES_BRANCH_CYCLES - 2'h1;
              state_nxt = MIES_WAIT;
            end
            default: begin
              pc_nxt = pc_r;
            end
          endcase
          if (i_instr.op != MIES_OP_NONE) begin
            pc_nxt = i_instr.pc + 11'h001;
          end
        end
      end
      MIES_WAIT: begin
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == 2'h1) begin
          pc_nxt    = tgt_r;
          pcld_nxt  = 1'b1;
          state_nxt = MIES_IDLE;
        end else begin
          flush_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = MIES_IDLE;
      end
    endcase
    // Busy is registered so the port comes straight from a flop
    busy_nxt = (state_nxt == MIES_WAIT);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= MIES_IDLE;
      cnt_r   <= 2'h0;
      pc_r    <= `MIES_PC_RST;
      tgt_r   <= `MIES_PC_RST;
      pcld_r  <= 1'b0;
      flush_r <= 1'b0;
      acc_r   <= `MIES_ACC_RST;
      zero_r  <= 1'b0;
      rw_r    <= '0;
      sw_r    <= 1'b0;
      sr_r    <= 1'b0;
      ssel_r  <= 4'h0;
      swd_r   <= `MIES_ACC_RST;
      push_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pc_r    <= pc_nxt;
      tgt_r   <= tgt_nxt;
      pcld_r  <= pcld_nxt;
      flush_r <= flush_nxt;
      acc_r   <= acc_nxt;
      zero_r  <= zero_nxt;
      rw_r    <= rw_nxt;
      sw_r    <= sw_nxt;
      sr_r    <= sr_nxt;
      ssel_r  <= ssel_nxt;
      swd_r   <= swd_nxt;
      push_r  <= push;
      busy_r  <= busy_nxt;
    end
  end

  assign o_busy       = busy_r;
  assign o_flush      = flush_r;
  assign o_pc_load    = pcld_r;
  assign o_pc         = pc_r;
  assign o_acc        = acc_r;
  assign o_zero       = zero_r;
  assign o_reg_wr     = rw_r;
  assign o_sec_wr     = sw_r;
  assign o_sec_rd     = sr_r;
  assign o_sec_sel    = ssel_r;
  assign o_sec_wdata  = swd_r;
  assign o_stack_ptr  = sptr;
  assign o_stack_push = push_r;
endmodule : mies_core

//--- bench/mies_core_checker.sv
`timescale 1ns/1ps
module mies_core_checker (
  input logic                  i_mclk,
  input logic                  i_nrst,
  input logic                  i_instr_valid,
  input mies_pkg::mies_instr_s i_instr,
  input logic [7:0]            i_reg_rdata,
  input logic [7:0]            i_sec_rdata,
  input logic                  o_busy,
  input logic                  o_flush,
  input logic                  o_pc_load,
  input logic [10:0]           o_pc,
  input logic [7:0]            o_acc,
  input logic                  o_zero,
  input mies_pkg::mies_regwr_s o_reg_wr,
  input logic                  o_sec_wr,
  input logic                  o_sec_rd,
  input logic [3:0]            o_sec_sel,
  input logic [7:0]            o_sec_wdata,
  input logic [2:0]            o_stack_ptr,
  input logic                  o_stack_push
);
  import mies_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  logic tk;
  logic sv;
  assign tk = i_instr_valid && !o_busy;
  assign sv = i_instr.sec_sel >= 4'h5;
  sequence s_head; o_flush && o_stack_push && o_busy; endsequence
  sequence s_trap; s_head ##1 o_flush ##1 o_pc_load && o_pc == 11'h001; endsequence
  a_trap_vector: assert property (tk && i_instr.op == MIES_OP_TRAP |=> s_trap)
    else $error("trap sequence wrong");
  a_call_target: assert property (tk && i_instr.op == MIES_OP_LONG_CALL_OP |=> s_head
    ##1 o_pc_load && o_pc == $past(i_instr.target, 2)) else $error("call wrong");
  a_jump_nopush: assert property (tk && i_instr.op == MIES_OP_LJUMP |=> !o_stack_push
    && !o_pc_load ##1 o_pc_load && o_pc == $past(i_instr.target, 2)) else $error("jump wrong");
  a_ptr_step: assert property (o_stack_push |-> o_stack_ptr == $past(o_stack_ptr) + 3'h1)
    else $error("stack pointer step wrong");
  a_or_imm: assert property (tk && i_instr.op == MIES_OP_OR_IMM |=>
    o_acc == ($past(o_acc) | $past(i_instr.imm))) else $error("or immediate wrong");
  a_zero_flag: assert property (tk && (i_instr.op == MIES_OP_OR_IMM ||
    i_instr.op == MIES_OP_OR_REG && !i_instr.dest_reg) |=> o_zero == (o_acc == 8'h00))
    else $error("zero flag wrong");
  a_or_reg: assert property (tk && i_instr.op == MIES_OP_OR_REG && i_instr.dest_reg |=>
    o_reg_wr.wr && o_reg_wr.data == ($past(o_acc) | $past(i_reg_rdata)) && $stable(o_acc))
    else $error("or register wrong");
  a_sec_store: assert property (tk && i_instr.op == MIES_OP_ST_SEC && sv |=> o_sec_wr &&
    o_sec_wdata == $past(o_acc) && o_sec_sel == $past(i_instr.sec_sel) && $stable(o_zero))
    else $error("store wrong");
  a_sec_load: assert property (tk && i_instr.op == MIES_OP_LD_SEC && sv |=> o_sec_rd &&
    o_acc == $past(i_sec_rdata) && $stable(o_zero)) else $error("load wrong");
  a_sec_refuse: assert property (tk && (i_instr.op == MIES_OP_ST_SEC ||
    i_instr.op == MIES_OP_LD_SEC) && !sv |=> !o_sec_wr && !o_sec_rd && $stable(o_acc))
    else $error("refused page access acted");
endmodule : mies_core_checker
bind mies_core mies_core_checker u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_reg_rdata(i_reg_rdata),
  .i_sec_rdata(i_sec_rdata), .o_busy(o_busy), .o_flush(o_flush), .o_pc_load(o_pc_load),
  .o_pc(o_pc), .o_acc(o_acc), .o_zero(o_zero), .o_reg_wr(o_reg_wr), .o_sec_wr(o_sec_wr),
  .o_sec_rd(o_sec_rd), .o_sec_sel(o_sec_sel), .o_sec_wdata(o_sec_wdata),
  .o_stack_ptr(o_stack_ptr),
  .o_stack_push(o_stack_push));

//--- bench/mcu_instruction_execute_subset_test.sv
`timescale 1ns/1ps
module mcu_instruction_execute_subset_test;
  import mies_pkg::*;
  logic        i_mclk, i_nrst, i_instr_valid;
  mies_instr_s i_instr;
  logic [7:0]  i_reg_rdata, i_sec_rdata, o_acc, o_sec_wdata, acc_m;
  logic        o_busy, o_flush, o_pc_load, o_zero, o_sec_wr, o_sec_rd, o_stack_push, zero_m;
  logic [10:0] o_pc;
  logic [2:0]  o_stack_ptr, ptr_m;
  logic [3:0]  o_sec_sel;
  mies_regwr_s o_reg_wr;
  logic [8:0]  r;
  integer      seed = 19084, error_cnt = 0, compares = 0, cyc = 0, i, n;
  mies_core DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_reg_rdata(i_reg_rdata), .i_sec_rdata(i_sec_rdata),
    .o_busy(o_busy), .o_flush(o_flush), .o_pc_load(o_pc_load), .o_pc(o_pc), .o_acc(o_acc),
    .o_zero(o_zero), .o_reg_wr(o_reg_wr), .o_sec_wr(o_sec_wr), .o_sec_rd(o_sec_rd),
    .o_sec_sel(o_sec_sel), .o_sec_wdata(o_sec_wdata), .o_stack_ptr(o_stack_ptr),
    .o_stack_push(o_stack_push));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Cut off a hung run well past the expected length
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end
  task chk(input logic [10:0] s, input logic [10:0] e);
    compares = compares + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function logic [8:0] f_or(input logic [7:0] a, input logic [7:0] b);
    return {(a | b) == 8'h00, a | b};
  endfunction : f_or
  // Issue one single-cycle op, then compare against the model next cycle
  task one();
    i_instr_valid = 1'b1;
    @(posedge i_mclk);
    #1;
    case (i_instr.op)
      MIES_OP_OR_IMM: {zero_m, acc_m} = f_or(acc_m, i_instr.imm);
      MIES_OP_OR_REG: begin
        r = f_or(acc_m, i_reg_rdata);
        zero_m = r[8];
        chk(o_reg_wr.wr, i_instr.dest_reg);
        if (i_instr.dest_reg) begin
          chk(o_reg_wr.data, r[7:0]);
          chk(o_reg_wr.addr, i_instr.reg_addr);
        end else begin
          acc_m = r[7:0];
        end
      end
      MIES_OP_ST_SEC: begin
        chk(o_sec_wr, i_instr.sec_sel >= 4'h5);
        if (o_sec_wr === 1'b1) chk(o_sec_wdata, acc_m);
      end
      default: begin
        chk(o_sec_rd, i_instr.sec_sel >= 4'h5);
        if (i_instr.sec_sel >= 4'h5) acc_m = i_sec_rdata;
      end
    endcase
    if ((i_instr.op == MIES_OP_ST_SEC || i_instr.op == MIES_OP_LD_SEC) &&
        i_instr.sec_sel >= 4'h5) chk(o_sec_sel, i_instr.sec_sel);
    chk(o_acc, acc_m);
    chk(o_zero, zero_m);
  endtask : one
  // Branch held against an OR that must be ignored while busy
  task br(input mies_op_e op, input logic [10:0] t, input logic [10:0] e, input int c);
    i_instr.op = op;
    i_instr.target = t;
    i_instr_valid = 1'b1;
    @(posedge i_mclk);
    #1;
    i_instr.op = MIES_OP_OR_IMM;
    i_instr.imm = 8'hff;
    n = 1;
    while (o_pc_load !== 1'b1 && n < 8) begin
      @(posedge i_mclk);
      #1;
      n = n + 1;
    end
    i_instr_valid = 1'b0;
    chk(11'(n), 11'(c));
    chk(o_pc, e);
    chk(o_acc, acc_m);
    if (op != MIES_OP_LJUMP) ptr_m = ptr_m + 3'h1;
    chk(o_stack_ptr, ptr_m);
    // One idle edge so the next request is not raised in the step valid fell
    @(posedge i_mclk);
    #1;
  endtask : br
  task end_sim();
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    i_nrst = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = '0;
    i_reg_rdata = 8'h00;
    i_sec_rdata = 8'h00;
    {acc_m, zero_m, ptr_m} = {8'h00, 1'b0, 3'h1};
    repeat (8) @(posedge i_mclk);
    #1;
    i_nrst = 1'b1;
    chk(o_stack_ptr, ptr_m);
    i_instr.op = MIES_OP_OR_IMM;
    one();
    for (i = 0; i < 40; i = i + 1) begin
      {i_instr.imm, i_instr.reg_addr, i_instr.dest_reg, i_instr.sec_sel, i_instr.pc} =
        31'($random(seed));
      i_instr.op = mies_op_e'(3'h2 + 3'({$random(seed)} % 4));
      {i_reg_rdata, i_sec_rdata} = 16'($random(seed));
      one();
    end
    // Refused select keeps the accumulator; then clear it so a stray OR would show
    i_instr.op = MIES_OP_LD_SEC;
    i_instr.sec_sel = 4'h4;
    i_sec_rdata = 8'hff;
    one();
    i_instr.sec_sel = 4'h5;
    i_sec_rdata = 8'h00;
    one();
    br(MIES_OP_LJUMP, 11'h7ff, 11'h7ff, 2);
    br(MIES_OP_LONG_CALL_OP, 11'h000, 11'h000, 2);
    br(MIES_OP_TRAP, 11'h555, 11'h001, 3);
    end_sim();
  end
endmodule : mcu_instruction_execute_subset_test
